// ===== dtc_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_ADDR_W        4
`define DTC_OFF_CTRL0     4'h0
`define DTC_OFF_MATCH0    4'h1
`define DTC_OFF_DUTY0     4'h2
`define DTC_OFF_STAT0     4'h3
`define DTC_OFF_CTRL1     4'h4
`define DTC_OFF_MATCH1    4'h5
`define DTC_OFF_DUTY1     4'h6
`define DTC_OFF_STAT1     4'h7
`define DTC_OFF_PRESC     4'h8
`define DTC_BIT_MODE_LO   0
`define DTC_BIT_MODE_HI   2
`define DTC_BIT_RUN       3
`define DTC_BIT_TAP_LO    4
`define DTC_BIT_TAP_HI    6
`define DTC_BIT_FF_INIT   7
`define DTC_CTRL_RESET    8'h00
`define DTC_MATCH_RESET   8'hff
`define DTC_DUTY_RESET    8'h80
`define DTC_TAP_SH0       11
`define DTC_TAP_SH1       7
`define DTC_TAP_SH2       5
`define DTC_TAP_SH3       3
`define DTC_TAP_EVENT     3'h7
`define DTC_PRESC_W       13
`endif

// ===== dtc_evt_src.sv
// event source: each level held four cycles, idle high
`timescale 1ns/1ns
module dtc_evt_src (
  input  wire logic ref_clk,
  input  wire logic go,
  output logic      ev
);
  logic [2:0] cnt_q = 3'h0;
  always_ff @(posedge ref_clk)
    if (go)
      cnt_q <= cnt_q + 3'h1;
  assign ev = ~cnt_q[2];
endmodule : dtc_evt_src

// ===== dtc_pkg.sv
// types shared by the dual timer/counter
package dtc_pkg;
  typedef enum logic [2:0] {
    DTC_MODE_TIMER = 3'h0,
    DTC_MODE_DIV   = 3'h1,
    DTC_MODE_PWM   = 3'h2
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] match;
    logic [7:0] duty_buf;
    logic [7:0] duty_act;
    logic [7:0] count;
    logic       ff;
    logic       ev_prev;
    logic       tick_prev;
    logic       irq;
  } dtc_chan_t;
endpackage : dtc_pkg

// ===== dtc_props.sv
// port assertions for the dual timer/counter
`timescale 1ns/1ns
module dtc_props #(
  parameter int CHANNELS = 2
) (
  input wire logic                ref_clk,
  input wire logic                reset_n,
  input wire logic [3:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_write,
  input wire logic                reg_read,
  input wire logic [7:0]          reg_rdata,
  input wire logic [CHANNELS-1:0] event_input_pin,
  input wire logic [CHANNELS-1:0] divider_out_pin,
  input wire logic [CHANNELS-1:0] duty_out_pin,
  input wire logic [CHANNELS-1:0] match_interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_pin; divider_out_pin == duty_out_pin; endproperty
  a_pin: assert property (p_pin) else $error("pins differ");
  property p_st; reg_read && reg_addr == 4'h3 |=>
    reg_rdata[0] == !$past(divider_out_pin[0]); endproperty
  a_st: assert property (p_st) else $error("status bad");
  // tap 2^3 and match of at least 1 keep interrupts 8 cycles apart
  property p_g0; match_interrupt[0] |=> !match_interrupt[0] [*7];
  endproperty
  a_g0: assert property (p_g0) else $error("irq0 close");
  property p_g1; match_interrupt[1] |=> !match_interrupt[1] [*3];
  endproperty
  a_g1: assert property (p_g1) else $error("irq1 close");
  property p_rst; $rose(reset_n) |->
    divider_out_pin == '1 && match_interrupt == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset bad");
  property p_c; reg_write && reg_addr == 4'h0 ##1 reg_read &&
    reg_addr == 4'h0 |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_c: assert property (p_c) else $error("ctrl bad");
  property p_m; reg_write && reg_addr == 4'h1 ##1 reg_read &&
    reg_addr == 4'h1 |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_m: assert property (p_m) else $error("match bad");
  property p_d; reg_write && reg_addr == 4'h2 ##1 reg_read &&
    reg_addr == 4'h2 |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_d: assert property (p_d) else $error("duty bad");
endmodule : dtc_props

// ===== dtc_timer.sv
// two 8-bit timer/event counters with divider and modulation outputs
//
// Contract
// - each counter runs timer, event, divider or modulation mode alone
// - mode field 000 timer/event, 001 divider, 010 modulation
// - timer counts tap ticks; on match interrupt, clear, keep counting
// - compare value written takes effect at once, no buffer
// - event mode counts falling edges; match interrupts and clears
// - divider mode toggles flip-flop on match, clears, interrupts
// - divider pin drives inverse of output flip-flop
// - flip-flop clears on reset; software loads it via init bit
// - stopped output holds; init bit changes only after the stop
// - control bit 3 runs, bit 7 is flip-flop init
// - modulation toggles on duty match and again on overflow
// - modulation pin drives inverse of output flip-flop
// - duty is double-buffered; loads at overflow, or at once stopped
// - duty reads return the buffered written value
// - taps are clock over 2^11,2^7,2^5,2^3, doubled when halving
`timescale 1ns/1ns
`include "dtc_cfg.svh"
module dtc_timer #(
  parameter int CHANNELS = 2
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic [`DTC_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [7:0]               reg_rdata,
  input  wire logic [CHANNELS-1:0]      event_input_pin,
  output logic      [CHANNELS-1:0]      divider_out_pin,
  output logic      [CHANNELS-1:0]      duty_out_pin,
  output logic      [CHANNELS-1:0]      match_interrupt
);
  import dtc_pkg::*;

  initial
  begin
    if (CHANNELS != 2)
      $error("dtc_timer serves exactly two channels");
  end

  typedef struct packed {
    dtc_chan_t [1:0]         ch;
    logic [`DTC_PRESC_W-1:0] presc;
    logic                    halve;
    logic [7:0]              rdata;
  } dtc_state_t;

  dtc_state_t state_q;
  dtc_state_t state_d;

  // tap bit of the free-running prescaler; its rising edge is one tick
  function automatic logic tap_level(input logic [2:0] sel,
                                     input logic [`DTC_PRESC_W-1:0] p,
                                     input logic halve);
    logic [3:0] sh;
    sh = 4'h0;
    case (sel[1:0])
      2'h0: sh = 4'(`DTC_TAP_SH0);
      2'h1: sh = 4'(`DTC_TAP_SH1);
      2'h2: sh = 4'(`DTC_TAP_SH2);
      default: sh = 4'(`DTC_TAP_SH3);
    endcase
    sh = sh + {3'h0, halve} - 4'h1;
    return p[sh];
  endfunction : tap_level

  function automatic logic [7:0] read_chan(input dtc_chan_t c,
                                           input logic [1:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      2'h0: v = c.ctrl;
      2'h1: v = c.match;
      2'h2: v = c.duty_buf;
      default: v = {6'h00, c.irq, c.ff};
    endcase
    return v;
  endfunction : read_chan

  always_comb
  begin
    logic       sel_ch;
    logic       tick;
    logic       ev;
    logic [7:0] wd;
    dtc_chan_t  c;
    sel_ch = 1'b0;
    tick   = 1'b0;
    ev     = 1'b0;
    wd     = reg_wdata;
    c      = '0;
    state_d = state_q;
    state_d.presc = state_q.presc + `DTC_PRESC_W'(1);
    sel_ch = reg_addr[2];
    for (int i = 0; i < 2; i++)
    begin
      c = state_q.ch[i];
      c.irq = 1'b0;
      ev = event_input_pin[i];
      c.ev_prev = ev;
      c.tick_prev = tap_level(c.ctrl[`DTC_BIT_TAP_HI:`DTC_BIT_TAP_LO],
                              state_q.presc, state_q.halve);
      if (c.ctrl[`DTC_BIT_TAP_HI:`DTC_BIT_TAP_LO] == `DTC_TAP_EVENT)
        tick = state_q.ch[i].ev_prev && !ev;
      else
        tick = c.tick_prev && !state_q.ch[i].tick_prev;
      if (c.ctrl[`DTC_BIT_RUN] && tick)
      begin
        case (dtc_mode_t'(c.ctrl[`DTC_BIT_MODE_HI:`DTC_BIT_MODE_LO]))
          DTC_MODE_PWM:
          begin
            if (c.count == 8'hff)
            begin
              c.count = 8'h00;
              c.ff = ~c.ff;
              c.irq = 1'b1;
              c.duty_act = c.duty_buf;
            end
            else
            begin
              c.count = c.count + 8'h01;
              if (c.count == c.duty_act)
                c.ff = ~c.ff;
            end
          end
          DTC_MODE_TIMER, DTC_MODE_DIV:
          begin
            c.count = c.count + 8'h01;
            if (c.count == c.match)
            begin
              c.count = 8'h00;
              c.irq = 1'b1;
              if (c.ctrl[`DTC_BIT_MODE_LO])
                c.ff = ~c.ff;
            end
          end
          default: c.count = c.count;
        endcase
      end
      if (!c.ctrl[`DTC_BIT_RUN])
        c.count = 8'h00;
      if (reg_write && sel_ch == i[0] && !reg_addr[3])
      begin
        if (reg_addr[1:0] == 2'h0)
        begin
          // init bit loads the flip-flop only from a stopped write
          if (!state_q.ch[i].ctrl[`DTC_BIT_RUN] && !wd[`DTC_BIT_RUN])
            c.ff = wd[`DTC_BIT_FF_INIT];
          c.ctrl = wd;
        end
        else if (reg_addr[1:0] == 2'h1)
          c.match = wd;
        else if (reg_addr[1:0] == 2'h2)
        begin
          c.duty_buf = wd;
          if (!c.ctrl[`DTC_BIT_RUN])
            c.duty_act = wd;
        end
      end
      state_d.ch[i] = c;
    end
    if (reg_write && reg_addr == `DTC_OFF_PRESC)
      state_d.halve = wd[0];
    state_d.rdata = 8'h00;
    if (reg_read)
    begin
      if (!reg_addr[3])
        state_d.rdata = read_chan(state_q.ch[sel_ch], reg_addr[1:0]);
      else if (reg_addr == `DTC_OFF_PRESC)
        state_d.rdata = {7'h00, state_q.halve};
      else
        state_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      for (int i = 0; i < 2; i++)
      begin
        state_q.ch[i].ctrl     <= `DTC_CTRL_RESET;
        state_q.ch[i].match    <= `DTC_MATCH_RESET;
        state_q.ch[i].duty_buf <= `DTC_DUTY_RESET;
        state_q.ch[i].duty_act <= `DTC_DUTY_RESET;
        state_q.ch[i].ev_prev  <= 1'b1;
      end
    end
    else
      state_q <= state_d;
  end

  // both waveform pins show the inverted flip-flop; stopped they hold
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      divider_out_pin[i] = ~state_q.ch[i].ff;
      duty_out_pin[i]    = ~state_q.ch[i].ff;
      match_interrupt[i] = state_q.ch[i].irq;
    end
  end

  assign reg_rdata = state_q.rdata;
endmodule : dtc_timer

// ===== tb.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`include "dtc_cfg.svh"
module tb;
  logic        ref_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        reg_write = 1'h0;
  logic        reg_read = 1'h0;
  logic        go = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [1:0]  dv, du, irq;
  wire  [1:0]  ev;
  logic [15:0] n;
  int          miscompares = 0;
  int          tests_run = 0;
  assign ev[0] = 1'h1;
  always #5 ref_clk = ~ref_clk;
  dtc_evt_src u_dtc_evt_src (.ref_clk, .go, .ev(ev[1]));
  dtc_timer u_dtc_timer (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .event_input_pin(ev),
    .divider_out_pin(dv), .duty_out_pin(du), .match_interrupt(irq));
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  task automatic acc(logic [3:0] a, logic [7:0] d, logic w, logic r);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= w;
    reg_read <= r & ~w;
    @(posedge ref_clk);
    reg_write <= 1'h0;
    reg_read <= r & w;
    if (w)
      @(posedge ref_clk);
    reg_read <= 1'h0;
    #1 if (r) chk("rdata", d, reg_rdata);
    @(posedge ref_clk);
  endtask : acc
  // gap between the (r-1)-th and the r-th next dv[0] change or interrupt
  task automatic gap(int s, int r, output logic [15:0] c);
    logic p, h;
    p = dv[0];
    repeat (r)
    begin
      c = 0;
      h = 0;
      while (!h && c < 16'h1388)
      begin
        @(posedge ref_clk);
        #1 c++;
        h = s < 2 ? irq[s] : dv[0] != p;
        p = dv[0];
      end
    end
  endtask : gap
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial
  begin
    // all tests need roughly 12000 cycles; allow over three times that
    #400000 miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    chk("pins", 16'h3, dv);
    reset_n <= 1'h1;
    acc(`DTC_OFF_MATCH0, `DTC_MATCH_RESET, 0, 1);
    acc(`DTC_OFF_DUTY1, `DTC_DUTY_RESET, 0, 1);
    acc(4'hf, 8'h00, 0, 1);
    acc(`DTC_OFF_MATCH0, 8'h02, 1, 1);
    acc(`DTC_OFF_CTRL0, 8'h38, 1, 1);
    gap(0, 2, n);
    chk("timer", 16'h10, n);
    acc(`DTC_OFF_PRESC, 8'h01, 1, 0);
    gap(0, 2, n);
    chk("halved", 16'h20, n);
    acc(`DTC_OFF_PRESC, 8'h00, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h30, 1, 1);
    acc(`DTC_OFF_CTRL0, 8'h20, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h28, 1, 0);
    gap(0, 2, n);
    chk("tap5", 16'h40, n);
    acc(`DTC_OFF_CTRL0, 8'h20, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h00, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h08, 1, 0);
    gap(0, 2, n);
    chk("tap11", 16'h1000, n);
    acc(`DTC_OFF_CTRL0, 8'h00, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h30, 1, 0);
    $display("timer test ends");
    acc(`DTC_OFF_CTRL0, 8'h31, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h39, 1, 0);
    gap(2, 2, n);
    chk("divider", 16'h10, n);
    acc(`DTC_OFF_CTRL0, 8'h31, 1, 0);
    n = dv;
    repeat (40) @(posedge ref_clk);
    chk("hold", n, dv);
    acc(`DTC_OFF_CTRL0, 8'h81, 1, 0);
    chk("init1", 16'h0, dv[0]);
    acc(`DTC_OFF_STAT0, 8'h01, 0, 1);
    acc(`DTC_OFF_CTRL0, 8'h01, 1, 0);
    chk("init0", 16'h1, dv[0]);
    $display("divider test ends");
    acc(`DTC_OFF_DUTY0, 8'h40, 1, 1);
    acc(`DTC_OFF_CTRL0, 8'h32, 1, 0);
    acc(`DTC_OFF_CTRL0, 8'h3a, 1, 0);
    gap(2, 2, n);
    chk("pwm tail", 16'h600, n);
    chk("duty pin", dv, du);
    gap(2, 1, n);
    chk("pwm head", 16'h200, n);
    chk("duty pin", dv, du);
    acc(`DTC_OFF_DUTY0, 8'h20, 1, 1);
    gap(2, 2, n);
    chk("new duty", 16'h100, n);
    acc(`DTC_OFF_CTRL0, 8'h32, 1, 0);
    n = du;
    repeat (40) @(posedge ref_clk);
    chk("pwm hold", n, du);
    $display("pwm test ends");
    acc(`DTC_OFF_MATCH1, 8'h03, 1, 1);
    acc(`DTC_OFF_CTRL1, 8'h70, 1, 0);
    acc(`DTC_OFF_CTRL1, 8'h78, 1, 0);
    go <= 1'h1;
    gap(1, 2, n);
    chk("events", 16'h18, n);
    $display("event test ends");
    print_verdict();
  end
endmodule : tb
bind dtc_timer dtc_props #(.CHANNELS(CHANNELS)) u_dtc_props (.ref_clk,
  .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .event_input_pin, .divider_out_pin, .duty_out_pin, .match_interrupt);
